// >>> verification/fsr_fault_status_and_translation_result_props.sv
`timescale 1ns/100ps
// ==========================================
// port checker
module fsr_fault_status_and_translation_result_props
  import fsr_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_b,
  input wire fsr_access_t   access,
  input wire fsr_trap_ctl_t trapCtl,
  input wire fsr_abort_t    abortIn,
  input wire fsr_xlate_t    xlateIn,
  input wire logic [63:0]   readData_r,
  input wire logic          readValid_r,
  input wire logic          trapToHyp_r,
  input wire logic          undefinedAccess_r,
  input wire logic [31:0]   faultStatus_r,
  input wire logic [63:0]   translationResult_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // updates only count when no access races them
  wire kAcc = access.valid && access.level == FSR_LVL_KERNEL;
  wire fSel = access.sel == FSR_SEL_FAULT;
  wire xOk  = xlateIn.valid && !xlateIn.aborted && !access.valid;
  wire abIn = abortIn.valid && !access.valid;
  a_user_undef:
    assert property (access.valid && access.level == FSR_LVL_USER
      |=> undefinedAccess_r && !readValid_r) else $error("user access not refused");
  a_hyp_free:
    assert property (access.valid && access.level == FSR_LVL_HYP
      |=> !trapToHyp_r && !undefinedAccess_r) else $error("hyp access refused");
  a_write_trap:
    assert property (kAcc && fSel && access.write && trapCtl.trapVmemWrites
      |=> trapToHyp_r) else $error("fault write not trapped");
  a_read_trap:
    assert property (kAcc && fSel && !access.write && trapCtl.trapVmemReads
      |=> trapToHyp_r && !readValid_r) else $error("fault read not trapped");
  a_five_trap:
    assert property (kAcc && fSel && trapCtl.trapGroupFive |=> trapToHyp_r)
      else $error("group five not trapped");
  a_seven_trap:
    assert property (kAcc && !fSel && trapCtl.trapGroupSeven |=> trapToHyp_r)
      else $error("group seven not trapped");
  a_ok_layout:
    assert property (xOk |=> !translationResult_r[0] && translationResult_r[11]
      && translationResult_r[8:7] != 2'h1 && translationResult_r[63:56] == $past(xlateIn.attr)
      && translationResult_r[39:12] == $past(xlateIn.outputAddress)) else $error("bad result");
  a_dev_share:
    assert property (xOk && xlateIn.deviceOrNonCacheable
      |=> translationResult_r[8:7] == FSR_DOM_OUTER) else $error("bad shareability");
  a_abort_code:
    assert property (abIn |=> faultStatus_r[5:0] == $past(abortIn.status)
      && (!faultStatus_r[12] || $past(abortIn.external))) else $error("bad fault status");
  // main scenarios reached
  c_trap: cover property (trapToHyp_r);
  c_undef: cover property (undefinedAccess_r);
  c_read: cover property (readValid_r);
endmodule
bind fsr_fault_status_and_translation_result fsr_fault_status_and_translation_result_props
  u_props (.clk(clk), .rst_b(rst_b), .access(access), .trapCtl(trapCtl),
  .abortIn(abortIn), .xlateIn(xlateIn), .readData_r(readData_r), .readValid_r(readValid_r),
  .trapToHyp_r(trapToHyp_r), .undefinedAccess_r(undefinedAccess_r),
  .faultStatus_r(faultStatus_r), .translationResult_r(translationResult_r));

// >>> verification/test_fault_status_and_translation_result.sv
`timescale 1ns/100ps
// ==========================================
// bench
module test_fault_status_and_translation_result
  import fsr_pkg::*;
;
  logic clk = 0, rst_b = 0;
  fsr_access_t access = '0;
  fsr_trap_ctl_t trapCtl = '0;
  fsr_abort_t abortIn = '0;
  fsr_xlate_t xlateIn = '0;
  logic [63:0] readData_r, translationResult_r;
  logic [31:0] faultStatus_r;
  logic readValid_r, trapToHyp_r, undefinedAccess_r, e;
  int err_count = 0, comparisons = 0;
  logic [5:0] codes [6] = '{FSR_ST_TRANSLATION, FSR_ST_PERMISSION, FSR_ST_SYNC_EXTERNAL,
                            FSR_ST_PARITY, FSR_ST_PC_ALIGN, FSR_ST_DEBUG};
  logic [1:0] domIn [3] = '{2'h3, 2'h1, 2'h0}, domEx [3] = '{2'h3, 2'h0, 2'h2};
  fsr_fault_status_and_translation_result DUT (.clk(clk), .rst_b(rst_b), .access(access),
    .trapCtl(trapCtl), .abortIn(abortIn), .xlateIn(xlateIn), .readData_r(readData_r),
    .readValid_r(readValid_r), .trapToHyp_r(trapToHyp_r), .undefinedAccess_r(undefinedAccess_r),
    .faultStatus_r(faultStatus_r), .translationResult_r(translationResult_r));
  // clock and watchdog, far beyond the few dozen cycles needed
  initial forever #50 clk = ~clk;
  initial begin
    #400000;
    err_count++;
    $display("FAIL watchdog exp done got hang");
    end_sim();
  end
  task chk(input string n, input logic [63:0] x, input logic [63:0] g);
    comparisons++;
    if (g !== x) begin
      err_count++;
      $display("FAIL %s exp %h got %h", n, x, g);
    end
  endtask
  // one access, held over one edge; outputs settled on return
  task acc(input logic w, input fsr_sel_t s, input fsr_level_t l, input logic [63:0] d);
    @(negedge clk) access <= '{1'h1, w, s, l, d};
    @(negedge clk) access <= '0;
  endtask
  task t_rw;
    acc(1'h1, FSR_SEL_RESULT, FSR_LVL_HYP, 64'h0123_4567_89AB_CDEF);
    acc(1'h0, FSR_SEL_RESULT, FSR_LVL_HYP, 64'h0);
    chk("result", 64'h0123_4567_89AB_CDEF, readData_r);
    acc(1'h1, FSR_SEL_FAULT, FSR_LVL_KERNEL, 64'hFFFF_FFFF_0000_0A5A);
    acc(1'h0, FSR_SEL_FAULT, FSR_LVL_KERNEL, 64'h0);
    chk("fault", 64'h0000_0A5A, readData_r);
  endtask
  // each trap control alone, then hyp with all set
  task t_traps;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk) trapCtl <= 4'h8 >> i;
      acc(i == 0, fsr_sel_t'(i == 3), FSR_LVL_KERNEL, 64'h0);
      chk("trap", 64'h1, {readValid_r, trapToHyp_r});
    end
    @(negedge clk) trapCtl <= 4'hF;
    acc(1'h0, FSR_SEL_FAULT, FSR_LVL_HYP, 64'h0);
    chk("hyp", 64'h2, {readValid_r, trapToHyp_r});
    @(negedge clk) trapCtl <= 4'h0;
    acc(1'h0, FSR_SEL_FAULT, FSR_LVL_USER, 64'h0);
    chk("user", 64'h1, {readValid_r, undefinedAccess_r});
    acc(1'h0, FSR_SEL_FAULT, FSR_LVL_KERNEL, 64'h0);
    chk("kept", 64'h0A5A, readData_r);
  endtask
  task t_abort;
    foreach (codes[i]) begin
      e = codes[i] == FSR_ST_SYNC_EXTERNAL || codes[i] == FSR_ST_PARITY;
      @(negedge clk) abortIn <= '{1'h1, codes[i], e, 1'h1, 1'h1};
      @(negedge clk) abortIn <= '0;
      chk("status", {15'h0, e, 3'h0, e, 6'h8, codes[i]}, faultStatus_r);
    end
  endtask
  // successes with each shareability case, then an aborted walk
  task t_xlate;
    foreach (domIn[i]) begin
      @(negedge clk) xlateIn <= '{1'h1, 1'h0, 8'h4F, 28'hABC_DEF0, domIn[i], i == 2, 1'h1, 6'h0, 12'h0};
      @(negedge clk) xlateIn <= '0;
      chk("ok", {8'h4F, 16'h0, 28'hABC_DEF0, 3'h4, domEx[i], 7'h0},
          translationResult_r & 64'hFF00_00FF_FFFF_F981);
    end
    @(negedge clk) xlateIn <= '{1'h1, 1'h1, 8'h0, 28'h0, 2'h0, 1'h0, 1'h0, FSR_ST_PERMISSION, 12'h0};
    @(negedge clk) xlateIn <= '0;
    chk("abort", {FSR_ST_PERMISSION, 1'h1}, translationResult_r[6:0]);
  endtask
  task end_sim;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // reset held 16 cycles, then the scenarios
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    t_rw();
    t_traps();
    t_abort();
    t_xlate();
    end_sim();
  end
endmodule

// >>> verilog/fsr_fault_status_and_translation_result.sv
`timescale 1ns/100ps
module fsr_fault_status_and_translation_result
  import fsr_pkg::*;
#(
  parameter bit HAS_HYP_LEVEL = 1'b1,
  parameter bit CLASSIFY_EXT  = 1'b1
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire fsr_access_t   access,
  input  wire fsr_trap_ctl_t trapCtl,
  input  wire fsr_abort_t    abortIn,
  input  wire fsr_xlate_t    xlateIn,
  output logic [63:0]        readData_r,
  output logic               readValid_r,
  output logic               trapToHyp_r,
  output logic               undefinedAccess_r,
  output logic [31:0]        faultStatus_r,
  output logic [63:0]        translationResult_r
);

  // ==========================================================================
  // helpers

  // sanitise shareability: reserved 01 never comes out of a translation
  function automatic logic [1:0] fsr_share(input logic [1:0] sh, input logic devNc);
    logic [1:0] r;
    r = sh;
    if (devNc) begin
      r = FSR_DOM_OUTER;
    end else if (sh == FSR_DOM_RSVD) begin
      r = FSR_DOM_NON;
    end
    return r;
  endfunction

  // ==========================================================================
  // access check and register update
  logic [31:0] faultNxt;
  logic [63:0] resultNxt;
  logic [63:0] rdNxt;
  logic        rvNxt;
  logic        trapNxt;
  logic        undefNxt;
  logic        trapHit;
  logic [31:0] fs;
  logic [63:0] tr;

  always_comb begin
    faultNxt  = faultStatus_r;
    resultNxt = translationResult_r;
    rdNxt     = 64'h0000_0000_0000_0000;
    rvNxt     = 1'b0;
    trapNxt   = 1'b0;
    undefNxt  = 1'b0;
    trapHit   = 1'b0;
    fs        = 32'h0000_0000;
    tr        = 64'h0000_0000_0000_0000;
    // hardware events: latest instruction abort overwrites status
    if (abortIn.valid) begin
      fs = FSR_RES1_MASK;
      fs[FSR_ST_LO +: FSR_ST_W] = abortIn.status;
      if (abortIn.status == FSR_ST_SYNC_EXTERNAL || abortIn.status == FSR_ST_PARITY) begin
        fs[FSR_ADDR_INV_BIT] = abortIn.faultAddrInvalid;
      end // otherwise zero
      if (CLASSIFY_EXT && abortIn.external) begin
        fs[FSR_KIND_BIT] = abortIn.externalAbortKind;
      end
      faultNxt = fs;
    end
    // translation completes with either layout, 64 bits each time
    if (xlateIn.valid) begin
      if (xlateIn.aborted) begin
        tr[FSR_TR_FIMPL_LO +: 12] = xlateIn.faultImpl;
        tr[FSR_TR_LONG] = 1'b1;
        tr[FSR_TR_FST_LO +: FSR_ST_W] = xlateIn.faultStatus;
        tr[FSR_TR_FAIL_BIT] = 1'b1;
      end else begin
        tr[FSR_TR_ATTR_LO +: 8] = xlateIn.attr;
        tr[FSR_TR_OA_LO +: 28] = xlateIn.outputAddress;
        tr[FSR_TR_LONG] = 1'b1;
        tr[FSR_TR_IMPL_BIT] = xlateIn.implBit;
        // bit 9 left zero: value carries no meaning
        tr[FSR_TR_DOMAIN_LO +: 2] = fsr_share(xlateIn.coherenceDomain,
                                              xlateIn.deviceOrNonCacheable);
        tr[FSR_TR_FAIL_BIT] = 1'b0;
      end
      resultNxt = tr;
    end
    // software access; instruction order beats concurrent hardware update
    if (access.valid) begin
      if (access.level == FSR_LVL_USER) begin
        undefNxt = 1'b1;
      end else if (access.level == FSR_LVL_KERNEL && HAS_HYP_LEVEL) begin
        if (access.sel == FSR_SEL_FAULT) begin
          trapHit = (access.write && trapCtl.trapVmemWrites)
                 || (!access.write && trapCtl.trapVmemReads)
                 || trapCtl.trapGroupFive;
        end else begin
          trapHit = trapCtl.trapGroupSeven;
        end
      end
      trapNxt = trapHit;
      if (!undefNxt && !trapHit) begin
        if (access.write) begin
          if (access.sel == FSR_SEL_FAULT) begin
            faultNxt = access.wdata[31:0];
          end else begin
            resultNxt = access.wdata;
          end
        end else begin
          rvNxt = 1'b1;
          rdNxt = (access.sel == FSR_SEL_FAULT) ? {32'h0000_0000, faultStatus_r}
                                                : translationResult_r;
        end
      end
    end
  end

  // stored fields hold no defined value after reset, so only the access response outputs reset
  always_ff @(posedge clk) begin
    faultStatus_r       <= faultNxt;
    translationResult_r <= resultNxt;
    if (!rst_b) begin
      readData_r        <= 64'h0000_0000_0000_0000;
      readValid_r       <= 1'b0;
      trapToHyp_r       <= 1'b0;
      undefinedAccess_r <= 1'b0;
    end else begin
      readData_r        <= rdNxt;
      readValid_r       <= rvNxt;
      trapToHyp_r       <= trapNxt;
      undefinedAccess_r <= undefNxt;
    end
  end

endmodule

// >>> verilog/fsr_pkg.sv
package fsr_pkg;

  // ==========================================================================
  // field positions, instruction fault status
  localparam int FSR_ADDR_INV_BIT = 16;
  localparam int FSR_KIND_BIT     = 12;
  localparam int FSR_LONG_BIT     = 9;
  localparam int FSR_ST_LO        = 0;
  localparam int FSR_ST_W         = 6;
  localparam logic [31:0] FSR_RES1_MASK = 32'h0000_0200;

  // fault status codes
  localparam logic [5:0] FSR_ST_TRANSLATION = 6'h04;
  localparam logic [5:0] FSR_ST_PERMISSION  = 6'h0C;
  localparam logic [5:0] FSR_ST_SYNC_EXTERNAL = 6'h10;
  localparam logic [5:0] FSR_ST_PARITY      = 6'h18;
  localparam logic [5:0] FSR_ST_PC_ALIGN    = 6'h21;
  localparam logic [5:0] FSR_ST_DEBUG       = 6'h22;

  // ==========================================================================
  // translation result layout
  localparam int FSR_TR_ATTR_LO = 56;
  localparam int FSR_TR_OA_LO   = 12;
  localparam int FSR_TR_LONG    = 11;
  localparam int FSR_TR_DOMAIN_LO = 7;
  localparam int FSR_TR_FST_LO    = 1;
  localparam int FSR_TR_IMPL_BIT  = 10;
  localparam int FSR_TR_FIMPL_LO  = 52;
  localparam int FSR_TR_FAIL_BIT  = 0;
  localparam logic [1:0] FSR_DOM_NON   = 2'h0;
  localparam logic [1:0] FSR_DOM_RSVD  = 2'h1;
  localparam logic [1:0] FSR_DOM_OUTER = 2'h2;
  localparam logic [1:0] FSR_DOM_INNER = 2'h3;

  // ==========================================================================
  // privilege levels and register selects
  typedef enum logic [1:0] {FSR_LVL_USER, FSR_LVL_KERNEL, FSR_LVL_HYP} fsr_level_t;
  typedef enum logic {FSR_SEL_FAULT, FSR_SEL_RESULT} fsr_sel_t;

  // system-register access request from the pipeline
  typedef struct packed {
    logic       valid;
    logic       write;
    fsr_sel_t   sel;
    fsr_level_t level;
    logic [63:0] wdata;
  } fsr_access_t;

  // trap controls from the hypervisor configuration registers
  typedef struct packed {
    logic trapVmemWrites;
    logic trapVmemReads;
    logic trapGroupFive;
    logic trapGroupSeven;
  } fsr_trap_ctl_t;

  // instruction abort report
  typedef struct packed {
    logic       valid;
    logic [5:0] status;
    logic       external;
    logic       externalAbortKind;
    logic       faultAddrInvalid;
  } fsr_abort_t;

  // translation completion report
  typedef struct packed {
    logic        valid;
    logic        aborted;
    logic [7:0]  attr;
    logic [27:0] outputAddress;
    logic [1:0]  coherenceDomain;
    logic        deviceOrNonCacheable;
    logic        implBit;
    logic [5:0]  faultStatus;
    logic [11:0] faultImpl;
  } fsr_xlate_t;

endpackage
